// [logic/tcc_channel.v]
// one timer channel: counter, clock selection, clock control and apb registers
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "tcc_regs.vh"
module tcc_channel (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq,
    input wire [4:0] internal_prescaled_clock,
    input wire [2:0] ext_clock_pin,
    input wire [2:0] io_line_a,
    input wire sync_trigger,
    input wire ext_trigger,
    input wire compare_trigger,
    input wire load_b_event,
    input wire compare_c_event,
    output reg [15:0] count_out
);

////////////////////////////////////////////////////////////////////////////////
// declarations

reg [15:0] channel_mode_reg;
reg [2:0] block_mode_reg;
reg [15:0] counter_value_reg;
reg [3:0] status_reg;
wire [3:0] status_next;
reg [3:0] mask_reg;
reg clk_en_reg;
reg clk_en_next;
reg started_reg;
reg started_next;
reg trig_pend_reg;
reg [2:0] pin_s1_reg;
reg [2:0] pin_s2_reg;
reg [2:0] ioa_s1_reg;
reg [2:0] ioa_s2_reg;
reg sel_prev_reg;
reg sel_raw;
reg gate_ok;
reg [31:0] rdata_next;
reg err_next;
wire [2:0] ext_sel;
wire sel_now;
wire [3:0] evt_set;
wire sr_wr;
wire [2:0] clks;
wire [1:0] burst;
wire inv;
wire wave;
wire wr_acc;
wire cmd_clock_enable_cmd;
wire cmd_clock_disable_cmd;
wire cmd_swtrg;
wire any_trig;
wire ev_ldb;
wire ev_cpc;
wire dis_evt;
wire stop_evt;
wire clk_edge;
wire advance;
wire wrap;

////////////////////////////////////////////////////////////////////////////////
// mode fields

assign clks = channel_mode_reg[`TCC_CMR_CLKS_MSB:`TCC_CMR_CLKS_LSB];
assign burst = channel_mode_reg[`TCC_CMR_BURST_MSB:`TCC_CMR_BURST_LSB];
assign inv = channel_mode_reg[`TCC_CMR_INV];
assign wave = channel_mode_reg[`TCC_CMR_WAVE];

////////////////////////////////////////////////////////////////////////////////
// external clock selections: two-flop synchronisers, then chaining mux

// pins and io lines are synchronised before the block mode select,
// so a select change never hands a raw asynchronous level to logic;
// only the second stages are read
// levels shorter than one pclk period may be missed
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pin_s1_reg <= 3'h0;
        pin_s2_reg <= 3'h0;
        ioa_s1_reg <= 3'h0;
        ioa_s2_reg <= 3'h0;
    end else if (ce) begin
        pin_s1_reg <= ext_clock_pin;
        pin_s2_reg <= pin_s1_reg;
        ioa_s1_reg <= io_line_a;
        ioa_s2_reg <= ioa_s1_reg;
    end
end

// per selection: external pin or io line a of another channel (chaining)
genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_ext
        assign ext_sel[gi] = block_mode_reg[gi] ? ioa_s2_reg[gi] : pin_s2_reg[gi];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// clock source selection, inversion and burst gate

// source mux; internal clocks come from pclk logic and need no synchroniser
always @* begin
    case (clks)
        3'd0: sel_raw = internal_prescaled_clock[0];
        3'd1: sel_raw = internal_prescaled_clock[1];
        3'd2: sel_raw = internal_prescaled_clock[2];
        3'd3: sel_raw = internal_prescaled_clock[3];
        3'd4: sel_raw = internal_prescaled_clock[4];
        3'd5: sel_raw = ext_sel[0];
        3'd6: sel_raw = ext_sel[1];
        default: sel_raw = ext_sel[2];
    endcase
end

// inversion swaps which edge of the source counts
assign sel_now = sel_raw ^ inv;

// burst gate: none, or one external selection that must be high
always @* begin
    case (burst)
        2'd1: gate_ok = ext_sel[0];
        2'd2: gate_ok = ext_sel[1];
        2'd3: gate_ok = ext_sel[2];
        default: gate_ok = 1'b1;
    endcase
end

// previous level of the selected clock for edge detection;
// a source or invert change that lifts the level counts as one edge
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sel_prev_reg <= 1'b0;
    end else if (ce) begin
        sel_prev_reg <= sel_now;
    end
end

// one-cycle enable on the rising edge of the (possibly inverted) clock
assign clk_edge = sel_now & ~sel_prev_reg & gate_ok;
assign advance = clk_edge & clk_en_reg & started_reg;
assign wrap = advance & ~trig_pend_reg & (counter_value_reg == `TCC_CNT_MAX);

////////////////////////////////////////////////////////////////////////////////
// apb decode: answer one cycle into the access phase

assign wr_acc = psel & penable & pready & pwrite;
assign cmd_clock_enable_cmd = wr_acc & (paddr == `TCC_CTRL_OFF) & pwdata[`TCC_CTRL_CLOCK_ENABLE_CMD];
assign cmd_clock_disable_cmd = wr_acc & (paddr == `TCC_CTRL_OFF) & pwdata[`TCC_CTRL_CLOCK_DISABLE_CMD];
assign cmd_swtrg = wr_acc & (paddr == `TCC_CTRL_OFF) & pwdata[`TCC_CTRL_SWTRG];

// read mux and unmapped address detection
always @* begin
    rdata_next = 32'h0000_0000;
    err_next = 1'b0;
    if (paddr == `TCC_CTRL_OFF) begin
        rdata_next = 32'h0000_0000; // commands read as zero
    end else if (paddr == `TCC_CMR_OFF) begin
        rdata_next = {16'h0000, channel_mode_reg};
    end else if (paddr == `TCC_CV_OFF) begin
        rdata_next = {16'h0000, counter_value_reg};
    end else if (paddr == `TCC_SR_OFF) begin
        rdata_next = {28'h000_0000, status_reg};
        rdata_next[`TCC_SR_CLOCK_ENABLED_STATUS] = clk_en_reg;
    end else if (paddr == `TCC_IMR_OFF) begin
        rdata_next = {28'h000_0000, mask_reg};
    end else if (paddr == `TCC_BMR_OFF) begin
        rdata_next = {29'h0000_0000, block_mode_reg};
    end else begin
        err_next = 1'b1;
    end
end

// pready rises on the first access cycle edge, drops after the handshake
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
    end else if (ce) begin
        if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= err_next;
            prdata <= pwrite ? 32'h0000_0000 : rdata_next;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
end

// writable configuration
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        channel_mode_reg <= `TCC_CMR_RST;
        block_mode_reg <= `TCC_BMR_RST;
        mask_reg <= `TCC_EVT_RST;
    end else if (ce && wr_acc) begin
        if (paddr == `TCC_CMR_OFF) begin
            channel_mode_reg <= pwdata[15:0];
        end else if (paddr == `TCC_IMR_OFF) begin
            mask_reg <= pwdata[3:0];
        end else if (paddr == `TCC_BMR_OFF) begin
            block_mode_reg <= pwdata[2:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// clock control: enable/disable and start/stop

assign any_trig = cmd_swtrg | sync_trigger | ext_trigger | compare_trigger;
assign ev_ldb = load_b_event & ~wave;
assign ev_cpc = compare_c_event & wave;
assign dis_evt = channel_mode_reg[`TCC_CMR_DIS] & (ev_ldb | ev_cpc);
assign stop_evt = channel_mode_reg[`TCC_CMR_STOP] & (ev_ldb | ev_cpc);

// enable state: disable beats enable in the same cycle
always @* begin
    clk_en_next = clk_en_reg;
    if (cmd_clock_disable_cmd || dis_evt) begin
        clk_en_next = 1'b0;
    end else if (cmd_clock_enable_cmd) begin
        clk_en_next = 1'b1;
    end
end

// start state: a trigger beats a stop; neither acts while disabled
always @* begin
    started_next = started_reg;
    if (clk_en_reg) begin
        if (any_trig) begin
            started_next = 1'b1;
        end else if (stop_evt) begin
            started_next = 1'b0;
        end
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        clk_en_reg <= 1'b0;
        started_reg <= 1'b0;
    end else if (ce) begin
        clk_en_reg <= clk_en_next;
        started_reg <= started_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// counter with deferred trigger reset

// a pending trigger turns the next counting step into a clear;
// count_out mirrors the counter so the output comes from a flip-flop
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        counter_value_reg <= `TCC_CNT_ZERO;
        count_out <= `TCC_CNT_ZERO;
    end else if (ce) begin
        if (advance && trig_pend_reg) begin
            counter_value_reg <= `TCC_CNT_ZERO;
            count_out <= `TCC_CNT_ZERO;
        end else if (advance) begin
            counter_value_reg <= counter_value_reg + 16'h0001;
            count_out <= counter_value_reg + 16'h0001;
        end
    end
end

// trigger pending: set by any trigger, used up by the next counting step;
// a new trigger in the clearing cycle stays pending for the step after
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        trig_pend_reg <= 1'b0;
    end else if (ce) begin
        if (any_trig) begin
            trig_pend_reg <= 1'b1;
        end else if (advance) begin
            trig_pend_reg <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// sticky status: hardware set beats write-one clear; masked interrupt

// event sources in status bit order
assign evt_set[`TCC_SR_OVF] = wrap;
assign evt_set[`TCC_SR_LDB] = ev_ldb;
assign evt_set[`TCC_SR_CPC] = ev_cpc;
assign evt_set[`TCC_SR_TRG] = any_trig;
assign sr_wr = wr_acc & (paddr == `TCC_SR_OFF);

// per bit: an event in the clearing cycle keeps the bit, so none is lost
genvar si;
generate
    for (si = 0; si < `TCC_EVT_W; si = si + 1) begin : g_status
        assign status_next[si] = evt_set[si] | (status_reg[si] & ~(sr_wr & pwdata[si]));
    end
endgenerate

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        status_reg <= `TCC_EVT_RST;
        irq <= 1'b0;
    end else if (ce) begin
        status_reg <= status_next;
        irq <= |(status_next & mask_reg);
    end
end

endmodule // tcc_channel
`default_nettype wire

// [logic/tcc_regs.vh]
// register map, field positions and reset values of the timer channel
`ifndef TCC_REGS_VH
`define TCC_REGS_VH
// byte offsets
`define TCC_CTRL_OFF 8'h00
`define TCC_CMR_OFF 8'h04
`define TCC_CV_OFF 8'h08
`define TCC_SR_OFF 8'h0C
`define TCC_IMR_OFF 8'h10
`define TCC_BMR_OFF 8'h14
// control register command bits
`define TCC_CTRL_CLOCK_ENABLE_CMD 0
`define TCC_CTRL_CLOCK_DISABLE_CMD 1
`define TCC_CTRL_SWTRG 2
// channel mode register fields
`define TCC_CMR_CLKS_LSB 0
`define TCC_CMR_CLKS_MSB 2
`define TCC_CMR_INV 3
`define TCC_CMR_BURST_LSB 4
`define TCC_CMR_BURST_MSB 5
`define TCC_CMR_STOP 6
`define TCC_CMR_DIS 7
`define TCC_CMR_WAVE 15
`define TCC_CMR_W 16
`define TCC_CMR_RST 16'h0000
// status register fields
`define TCC_SR_OVF 0
`define TCC_SR_LDB 1
`define TCC_SR_CPC 2
`define TCC_SR_TRG 3
`define TCC_SR_CLOCK_ENABLED_STATUS 16
`define TCC_EVT_W 4
`define TCC_EVT_RST 4'h0
// block mode register: one chaining select per external selection
`define TCC_BMR_W 3
`define TCC_BMR_RST 3'h0
// counter
`define TCC_CNT_W 16
`define TCC_CNT_MAX 16'hFFFF
`define TCC_CNT_ZERO 16'h0000
`endif

// [testbench/tcc_channel_properties.sv]
// port assertions for the timer channel
`timescale 1ns/10ps
`default_nettype none
`include "tcc_regs.vh"
module tcc_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic [15:0] count_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic cv_rd;
    // completed read of the counter value
    assign cv_rd = pready && !pwrite && paddr == `TCC_CV_OFF;
    ////////////////////////////////////////////////////////////////
    chk_count_step: assert property ($changed(count_out) |->
        count_out == $past(count_out) + 16'h0001 || count_out == 16'h0000)
        else $error("count moved by more than one");
    chk_cv_live: assert property (cv_rd |->
        prdata[15:0] == count_out || prdata[15:0] == $past(count_out))
        else $error("counter read not live");
    chk_cv_upper: assert property (cv_rd |-> prdata[31:16] == 16'h0000)
        else $error("counter read upper half not zero");
    chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error answer malformed");
    chk_ready_pulse: assert property (pready && ce |=> !pready)
        else $error("ready longer than one cycle");
    chk_ready_first: assert property (psel && penable && ce && !$past(penable) |=> pready)
        else $error("ready not one cycle after access");
    chk_freeze_count: assert property (!ce |=> $stable(count_out))
        else $error("count moved while frozen");
    chk_freeze_irq: assert property (!ce |=> $stable(irq))
        else $error("irq moved while frozen");
    cover property (pready && pslverr);
    cover property ($rose(irq));
    cover property (cv_rd);
endmodule // tcc_properties
bind tcc_channel tcc_properties u_props (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .irq, .count_out);
`default_nettype wire

// [testbench/tcc_channel_tb.sv]
// self-checking testbench for the timer channel
`timescale 1ns/10ps
`default_nettype none
`include "tcc_regs.vh"
module tcc_channel_tb;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rv;
    logic pready, pslverr, irq, er, lb = 0, cc = 0;
    logic [4:0] ipc = 0;
    logic [2:0] run = 0, lvl = 0, trg = 0, pin, ioa;
    logic [15:0] count_out;
    int mismatches = 0, num_checks = 0;
    always #2.5 pclk = ~pclk;
    tcc_ext_src u_src (.pclk, .run, .lvl, .ext_clock_pin(pin), .io_line_a(ioa));
    tcc_channel dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .internal_prescaled_clock(ipc),
        .ext_clock_pin(pin), .io_line_a(ioa), .sync_trigger(trg[0]), .ext_trigger(trg[1]),
        .compare_trigger(trg[2]), .load_b_event(lb), .compare_c_event(cc), .count_out);
    ////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (mismatches == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer, held until pready is sampled
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cnt(logic [15:0] e);
        chk("count", {16'h0000, e}, {16'h0000, count_out});
    endtask
    task automatic sr16(logic e);
        apb(1'b0, `TCC_SR_OFF, 32'h0000_0000);
        chk("clock enabled", {31'h0, e}, {31'h0, rv[16]});
    endtask
    task automatic trig;
        apb(1'b1, `TCC_CTRL_OFF, 32'h0000_0004);
    endtask
    task automatic start;
        apb(1'b1, `TCC_CTRL_OFF, 32'h0000_0001);
        trig;
    endtask
    // rising edges on all internal clocks
    task automatic tick(int n);
        repeat (n) begin
            @(posedge pclk);
            ipc <= 5'h1f;
            repeat (2) @(posedge pclk);
            ipc <= 5'h00;
            repeat (3) @(posedge pclk);
        end
    endtask
    // one-cycle load b (c=0) or compare c (c=1) event
    task automatic pulse(logic c);
        @(posedge pclk);
        lb <= !c;
        cc <= c;
        @(posedge pclk);
        lb <= 1'b0;
        cc <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic ext_run(int n);
        @(posedge pclk);
        run <= 3'h1;
        repeat (16 * n) @(posedge pclk);
        run <= 3'h0;
        repeat (6) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0000_0000);
            chk("reset read", 32'h0000_0000, rv);
        end
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0, er});
    endtask
    task automatic t_count;
        apb(1'b1, `TCC_CMR_OFF, 32'h0000_0000);
        start;
        tick(5);
        cnt(4);
        trig;
        cnt(4);
        tick(3);
        apb(1'b0, `TCC_CV_OFF, 32'h0000_0000);
        chk("live value", 32'h0000_0002, rv);
        sr16(1'b1);
    endtask
    task automatic t_disable;
        apb(1'b1, `TCC_CTRL_OFF, 32'h0000_0002);
        sr16(1'b0);
        trig;
        tick(2);
        cnt(2);
        start;
        tick(2);
        cnt(1);
    endtask
    task automatic t_stop;
        apb(1'b1, `TCC_IMR_OFF, 32'h0000_0002);
        apb(1'b1, `TCC_CMR_OFF, 32'h0000_0040);
        pulse(1'b0);
        chk("irq raised", 32'h0000_0001, {31'h0, irq});
        tick(2);
        cnt(1);
        sr16(1'b1);
        apb(1'b1, `TCC_SR_OFF, 32'h0000_0002);
        apb(1'b1, `TCC_IMR_OFF, 32'h0000_0000);
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
        trig;
        tick(3);
        cnt(2);
        apb(1'b1, `TCC_CMR_OFF, 32'h0000_8080);
        pulse(1'b0);
        sr16(1'b1);
        pulse(1'b1);
        sr16(1'b0);
        start;
        apb(1'b1, `TCC_CMR_OFF, 32'h0000_0080);
        pulse(1'b0);
        sr16(1'b0);
    endtask
    task automatic t_ext;
        apb(1'b1, `TCC_CMR_OFF, 32'h0000_0005);
        start;
        ext_run(2);
        cnt(3);
        apb(1'b1, `TCC_BMR_OFF, 32'h0000_0001);
        trig;
        ext_run(2);
        cnt(1);
        apb(1'b1, `TCC_BMR_OFF, 32'h0000_0000);
    endtask
    task automatic t_invert;
        ipc <= 5'h1f;
        apb(1'b1, `TCC_CMR_OFF, 32'h0000_0008);
        trig;
        ipc <= 5'h00;
        repeat (4) @(posedge pclk);
        cnt(0);
        ipc <= 5'h1f;
        repeat (4) @(posedge pclk);
        cnt(0);
        ipc <= 5'h00;
        repeat (4) @(posedge pclk);
        cnt(1);
    endtask
    task automatic t_burst;
        apb(1'b1, `TCC_CMR_OFF, 32'h0000_0010);
        lvl <= 3'h1;
        repeat (6) @(posedge pclk);
        trig;
        tick(3);
        cnt(2);
        ce <= 1'b0;
        tick(2);
        ce <= 1'b1;
        cnt(2);
        lvl <= 3'h0;
        repeat (6) @(posedge pclk);
        tick(2);
        cnt(2);
    endtask
    // each hardware trigger restarts a clock stopped by load b or compare c
    task automatic t_trig;
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `TCC_CMR_OFF, (i == 2) ? 32'h0000_8040 : 32'h0000_0040);
            pulse(i == 2);
            tick(1);
            cnt((i == 0) ? 16'h0002 : 16'h0001);
            sr16(1'b1);
            @(posedge pclk);
            trg <= 3'(1 << i);
            @(posedge pclk);
            trg <= 3'h0;
            tick(2);
            cnt(1);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_count;
        t_disable;
        t_stop;
        t_ext;
        t_invert;
        t_burst;
        t_trig;
        complete_run;
    end
    // watchdog
    initial begin
        #50000;
        mismatches++;
        complete_run;
    end
endmodule // tcc_channel_tb
`default_nettype wire

// [testbench/tcc_ext_src.sv]
// model of the external clock pins and chained io lines
`timescale 1ns/10ps
`default_nettype none
module tcc_ext_src #(parameter int HALF = 4) (
    input wire logic pclk,
    input wire logic [2:0] run,
    input wire logic [2:0] lvl,
    output logic [2:0] ext_clock_pin,
    output logic [2:0] io_line_a
);
    int cnt = 0;
    // phase counter restarts whenever all lines stand still
    always @(posedge pclk) begin
        cnt <= (run == 3'h0) ? 0 : cnt + 1;
    end
    // levels last HALF pclk or more; idle lines hold lvl
    always @(posedge pclk) begin
        for (int n = 0; n < 3; n++) begin
            if (!run[n]) begin
                ext_clock_pin[n] <= lvl[n];
                io_line_a[n] <= lvl[n];
            end else begin
                if (cnt % HALF == HALF - 1) ext_clock_pin[n] <= ~ext_clock_pin[n];
                if (cnt % (2 * HALF) == 2 * HALF - 1) io_line_a[n] <= ~io_line_a[n];
            end
        end
    end
endmodule // tcc_ext_src
`default_nettype wire
